// ==== inc/flash_params.svh ====
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL 12'hFF8
`define IDX_PAGE 12'hFF9
`define IDX_OFS_LO 12'hFFA
`define IDX_OFS_HI 12'hFFB
`define IDX_DATA 12'hFFC

// Control register codes
`define CODE_RESET 8'h00
`define CODE_PROT_SEL 8'h5E
`define CODE_PAGE_ERASE 8'h95
`define CODE_MASS_ERASE 8'h63
`define CODE_KEY1 8'hA5
`define CODE_KEY2 8'h5A

// Status bits, read at the control index
`define ST_BUSY_BIT 0
`define ST_UNLOCK_BIT 1
`define ST_PROTSEL_BIT 2
`define ST_REFUSED_BIT 3

// Reset values and geometry
`define SECTOR_LOCK_RESET 8'h00
`define PAGE_RESET 8'h00
`define ERASED_BYTE 8'hFF
`define FLASH_BYTES 16384
`define PAGE_LAST 14'h01FF
`define FLASH_LAST 14'h3FFF

// Byte program time
`define PROG_TIME_NS 100
`define CLOCK_PERIOD_NS 10
`define PROG_CYCLES ((`PROG_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ==== inc/flash_pkg.sv ====
package flash_pkg;

	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] index;
		logic [7:0] data;
	} bus_req_t;

	typedef struct packed {
		logic prog;
		logic pageErase;
		logic massErase;
		logic [13:0] addr;
		logic [7:0] data;
	} flash_cmd_t;

	typedef enum logic [2:0] {
		ST_LOCKED,
		ST_KEY1,
		ST_UNLOCKED,
		ST_PROG,
		ST_ERASE
	} ctrl_state_t;

endpackage : flash_pkg

// ==== design/avm_byte_slave.sv ====
`timescale 1ns/1ns
module avm_byte_slave
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [13:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output flash_pkg::bus_req_t busReq,
	input wire logic [7:0] readByte
);
	import flash_pkg::*;

	logic take;

	// One answer per request; waitrequest drops for exactly one cycle
	assign take = (read | write) & waitrequest;

	always_comb
	begin
		busReq.read = take & read;
		busReq.write = take & write & byteenable[0];
		busReq.index = address[13:2];
		busReq.data = writedata[7:0];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~take;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			readdata <= 32'h00000000;
		else if (take & read)
			readdata <= {24'h000000, readByte};
	end

endmodule : avm_byte_slave

// ==== design/flash_byte_array.sv ====
`timescale 1ns/1ns
`include "flash_params.svh"
module flash_byte_array
(
	input wire logic clock,
	input wire logic rst_n,
	input flash_pkg::flash_cmd_t cmd,
	input wire logic [13:0] readIndex,
	output logic [7:0] readByte,
	output logic busy,
	output logic done
);
	import flash_pkg::*;

	localparam logic [7:0] PROG_LAST = 8'(`PROG_CYCLES - 1);

	logic [7:0] mem [0:`FLASH_BYTES-1];
	logic [13:0] cnt;
	logic [13:0] endIdx;
	logic isProg;
	logic [7:0] progData;
	logic [7:0] timer;

	assign readByte = mem[readIndex];

	////////////////////////////////////////////////////////////////
	// Sequencer: one byte per cycle for erase, fixed wait for program
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 14'h0000;
			endIdx <= 14'h0000;
			isProg <= 1'b0;
			progData <= 8'hFF;
			timer <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			if (!busy && (cmd.prog | cmd.pageErase | cmd.massErase))
			begin
				busy <= 1'b1;
				isProg <= cmd.prog;
				progData <= cmd.data;
				timer <= PROG_LAST;
				if (cmd.massErase)
				begin
					cnt <= 14'h0000;
					endIdx <= `FLASH_LAST;
				end
				else if (cmd.pageErase)
				begin
					// Page erase walks all 512 bytes of the page
					cnt <= {cmd.addr[13:9], 9'h000};
					endIdx <= {cmd.addr[13:9], 9'h000} | `PAGE_LAST;
				end
				else
					cnt <= cmd.addr;
			end
			else if (busy)
			begin
				if (isProg ? (timer == 8'h00) : (cnt == endIdx))
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				else if (isProg)
					timer <= timer - 8'h01;
				else
					cnt <= cnt + 14'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Cell array; not reset, it models non-volatile contents
	always_ff @(posedge clock)
	begin
		if (busy && isProg && timer == 8'h00)
			mem[cnt] <= mem[cnt] & progData;
		else if (busy && !isProg)
			mem[cnt] <= `ERASED_BYTE;
	end

endmodule : flash_byte_array

// ==== design/flash_program_erase_control.sv ====
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
`include "flash_params.svh"
//Contract
// - Reset clears every sector lock bit
// - Lock writes only set bits; reset clears
// - Code 5E maps lock register on page address
// - Other control codes restore page register access
// - Selected lock register readable, writable at FF9
// - Control write 00 resets the controller
// - Protected sector: program and erase refused
// - Programming only inside the active page
// - Erased reads FF; program only clears bits
// - Processor stalled during program or erase
// - Page stays unlocked after byte program
// - Other control writes end programming, relock
// - Page erase fills 512 bytes with FF
// - Code 95 erases unprotected active page
// - Page erase completion relocks controller
// - Code 63 from debug port mass erases
module flash_program_erase_control
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [13:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic debugPort,
	output logic cpuStall
);
	import flash_pkg::*;

	bus_req_t busReq;
	flash_cmd_t flashCmd;
	ctrl_state_t state;
	logic protSelect;
	logic [7:0] sectorLock;
	logic [7:0] pageSel;
	logic [4:0] activePage;
	logic [8:0] progOffset;
	logic refused;
	logic flashBusy;
	logic flashDone;
	logic [7:0] flashByte;
	logic [7:0] readByte;
	logic ctrlWr;
	logic pageWr;
	logic dataWr;
	logic activeLocked;
	logic wantErase;
	logic wantMass;
	logic wantProg;

	function automatic logic sector_locked(input logic [7:0] locks, input logic [4:0] page);
		sector_locked = locks[page[4:2]];
	endfunction : sector_locked

	////////////////////////////////////////////////////////////////
	// Bus slave and cell array
	avm_byte_slave bus
	(
		.clock(clock),
		.rst_n(rst_n),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.busReq(busReq),
		.readByte(readByte)
	);

	flash_byte_array cells
	(
		.clock(clock),
		.rst_n(rst_n),
		.cmd(flashCmd),
		.readIndex({activePage, progOffset}),
		.readByte(flashByte),
		.busy(flashBusy),
		.done(flashDone)
	);

	////////////////////////////////////////////////////////////////
	// Decode
	// Control and data writes are dropped while an operation runs: the processor is stalled then
	assign ctrlWr = busReq.write && busReq.index == `IDX_CTRL && !cpuStall;
	assign pageWr = busReq.write && busReq.index == `IDX_PAGE;
	assign dataWr = busReq.write && busReq.index == `IDX_DATA && !cpuStall;
	assign activeLocked = sector_locked(sectorLock, activePage);
	assign wantErase = ctrlWr && busReq.data == `CODE_PAGE_ERASE && state == ST_UNLOCKED;
	assign wantMass = ctrlWr && busReq.data == `CODE_MASS_ERASE && state == ST_UNLOCKED;
	assign wantProg = dataWr && state == ST_UNLOCKED;

	always_comb
	begin
		flashCmd.pageErase = wantErase && !activeLocked;
		flashCmd.massErase = wantMass && debugPort && sectorLock == 8'h00;
		flashCmd.prog = wantProg && !activeLocked;
		flashCmd.addr = {activePage, progOffset};
		flashCmd.data = busReq.data;
	end

	always_comb
	begin
		case (busReq.index)
			`IDX_CTRL:
				readByte = {4'h0, refused, protSelect, state == ST_UNLOCKED, cpuStall};
			`IDX_PAGE:
				readByte = protSelect ? sectorLock : pageSel;
			`IDX_OFS_LO:
				readByte = progOffset[7:0];
			`IDX_OFS_HI:
				readByte = {7'h00, progOffset[8]};
			`IDX_DATA:
				readByte = flashByte;
			default:
				readByte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Sector lock and page select share one address
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			sectorLock <= `SECTOR_LOCK_RESET;
		else if (pageWr && protSelect)
			sectorLock <= sectorLock | busReq.data;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pageSel <= `PAGE_RESET;
		else if (pageWr && !protSelect)
			pageSel <= busReq.data;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			protSelect <= 1'b0;
		else if (ctrlWr)
			protSelect <= busReq.data == `CODE_PROT_SEL;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			progOffset <= 9'h000;
		else if (busReq.write && busReq.index == `IDX_OFS_LO)
			progOffset[7:0] <= busReq.data;
		else if (busReq.write && busReq.index == `IDX_OFS_HI)
			progOffset[8] <= busReq.data[0];
	end

	////////////////////////////////////////////////////////////////
	// Refusal flag; a new refusal wins over the clear
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			refused <= 1'b0;
		else if ((wantErase || wantProg) && activeLocked)
			refused <= 1'b1;
		else if (wantMass && !flashCmd.massErase)
			refused <= 1'b1;
		else if (ctrlWr && busReq.data == `CODE_RESET)
			refused <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Lock sequencer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_LOCKED;
			activePage <= 5'h00;
		end
		else
		begin
			case (state)
				ST_LOCKED:
					if (ctrlWr && busReq.data == `CODE_KEY1)
						state <= ST_KEY1;
				ST_KEY1:
					if (ctrlWr)
					begin
						if (busReq.data == `CODE_KEY2)
						begin
							state <= ST_UNLOCKED;
							activePage <= pageSel[4:0];
						end
						else
							state <= ST_LOCKED;
					end
				ST_UNLOCKED:
					if (flashCmd.pageErase || flashCmd.massErase)
						state <= ST_ERASE;
					else if (flashCmd.prog)
						state <= ST_PROG;
					else if (ctrlWr && !wantErase && !wantMass)
						state <= ST_LOCKED;
				ST_PROG:
					if (flashDone)
						state <= ST_UNLOCKED;
				ST_ERASE:
					if (flashDone)
						state <= ST_LOCKED;
				default:
					state <= ST_LOCKED;
			endcase
		end
	end

	// Stall rises with the command and falls after the done pulse
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cpuStall <= 1'b0;
		else if (flashCmd.pageErase || flashCmd.massErase || flashCmd.prog)
			cpuStall <= 1'b1;
		else if (flashDone)
			cpuStall <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_op_start;
		flashCmd.pageErase || flashCmd.massErase || flashCmd.prog;
	endsequence

	sequence s_erase_end;
		flashDone && state == ST_ERASE;
	endsequence

	// Ten busy cycles, then the done pulse
	sequence s_prog_run;
		flashBusy [*8] ##3 flashDone;
	endsequence

	a_lock_after_reset: assert property (!$past(rst_n) |-> sectorLock == 8'h00)
		else $error("sector locks not clear after reset");
	a_lock_only_sets: assert property ($past(rst_n) |-> (sectorLock & $past(sectorLock)) == $past(sectorLock))
		else $error("sector lock bit cleared");
	a_prot_select_on: assert property (ctrlWr && busReq.data == 8'h5E |=> protSelect)
		else $error("protect register not selected");
	a_prot_select_off: assert property (ctrlWr && busReq.data != 8'h5E |=> !protSelect)
		else $error("protect register still selected");
	a_prot_readback: assert property (busReq.read && busReq.index == 12'hFF9 && protSelect |=> readdata == {24'h000000, $past(sectorLock)})
		else $error("protect register readback wrong");
	a_reset_code: assert property (ctrlWr && busReq.data == 8'h00 && state != ST_ERASE && state != ST_PROG |=> state == ST_LOCKED && !refused)
		else $error("code 00 did not reset controller");
	a_protected_refused: assert property ((wantErase || wantProg) && activeLocked |-> !flashCmd.pageErase && !flashCmd.prog ##1 refused)
		else $error("protected sector not refused");
	a_stall_while_busy: assert property (s_op_start |=> cpuStall throughout flashBusy [*1])
		else $error("processor not stalled");
	a_prog_keeps_open: assert property (flashDone && state == ST_PROG |=> state == ST_UNLOCKED)
		else $error("page locked after byte program");
	a_other_code_relocks: assert property (state == ST_UNLOCKED && ctrlWr && !wantErase && !wantMass |=> state == ST_LOCKED)
		else $error("controller not relocked");
	a_erase_relocks: assert property (s_erase_end |=> state == ST_LOCKED ##1 !cpuStall)
		else $error("controller not relocked after erase");
	a_mass_debug_only: assert property (flashCmd.massErase |-> debugPort && sectorLock == 8'h00)
		else $error("mass erase without debug port");
	a_locked_ignores: assert property (state != ST_UNLOCKED |-> !flashCmd.prog && !flashCmd.pageErase && !flashCmd.massErase)
		else $error("command accepted while locked");
	a_status_busy: assert property (busReq.read && busReq.index == 12'hFF8 |=> readdata[0] == $past(cpuStall))
		else $error("status busy bit wrong");
	a_page_erase_length: assert property (flashCmd.pageErase |=> flashBusy [*8] ##[505:505] flashDone)
		else $error("page erase length wrong");
	a_stall_covers_busy: assert property (flashBusy |-> cpuStall)
		else $error("processor running during operation");
	a_stall_release: assert property (flashDone |=> !cpuStall)
		else $error("processor not released after operation");
	a_prog_address: assert property (flashCmd.prog |=> cells.cnt == {$past(activePage), $past(progOffset)})
		else $error("program outside active page");
	a_erase_starts: assert property (wantErase && !activeLocked |=> state == ST_ERASE && cpuStall)
		else $error("page erase not started");
	a_prog_duration: assert property (flashCmd.prog |=> s_prog_run)
		else $error("program time wrong");
	a_refused_holds: assert property (refused && !(ctrlWr && busReq.data == 8'h00) |=> refused)
		else $error("refused flag lost");
	a_lock_untouched: assert property (pageWr && !protSelect |=> sectorLock == $past(sectorLock))
		else $error("page write changed sector locks");
	a_page_kept: assert property (pageWr && protSelect |=> pageSel == $past(pageSel))
		else $error("lock write changed page select");

endmodule : flash_program_erase_control

// ==== tb/cpu_dbg_host.sv ====
`timescale 1ns/1ns
`include "flash_params.svh"
module cpu_dbg_host
(
	input wire logic clock,
	output logic [13:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	output logic debugPort,
	input wire logic waitrequest,
	input wire logic [31:0] readdata
);
	initial
	begin
		address = 14'h0000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		debugPort = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One access; enter right after a rising edge
	task automatic xfer(input logic isRead, input logic [11:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		read <= isRead;
		write <= !isRead;
		writedata <= {24'h000000, d};
		@(posedge clock);
		while (waitrequest !== 1'b0)
		begin
			n++;
			if (n > 100)
				tb_top.conclude(1);
			@(posedge clock);
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		// Released data must not look held
		writedata <= ~writedata;
		@(posedge clock);
	endtask : xfer

	////////////////////////////////////////////////////////////////////////////////
	// Status polling, bounded; no new operation until idle
	task automatic waitIdle();
		logic [7:0] s;
		int n;
		n = 0;
		s = 8'h01;
		while (s[`ST_BUSY_BIT] !== 1'b0)
		begin
			xfer(1'b1, `IDX_CTRL, 8'h00, s);
			n++;
			if (n > 20000)
				tb_top.conclude(1);
		end
	endtask : waitIdle

	// Debug-port level; only this model drives it
	task automatic setDebug(input logic v);
		debugPort <= v;
	endtask : setDebug
endmodule : cpu_dbg_host

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`include "flash_params.svh"
module tb_top;
	import flash_pkg::*;
	logic clock;
	logic rst_n = 1'b0;
	logic [13:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic debugPort;
	logic cpuStall;
	int n_errors = 0;
	int checked = 0;
	logic [15:0] expQ[$];
	logic [15:0] e;
	logic [7:0] q;
	logic [8:0] ofs;
	logic [7:0] d1;
	logic [7:0] d2;

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	cpu_dbg_host host_u
	(
		.clock(clock), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .debugPort(debugPort),
		.waitrequest(waitrequest), .readdata(readdata)
	);

	flash_program_erase_control dut_u
	(
		.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .debugPort(debugPort), .cpuStall(cpuStall)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude(input int extra);
		n_errors += extra;
		$display("checked=%0d errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		checked++;
		if ((got & m) !== (exp & m))
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// Oldest note matched to each answered read; poll reads carry no note
	always @(posedge clock)
		if (read === 1'b1 && waitrequest === 1'b0 && expQ.size() > 0)
		begin
			e = expQ.pop_front();
			cmp(readdata[7:0], e[7:0], e[15:8]);
		end

	task automatic chk(input logic [11:0] idx, input logic [7:0] exp, input logic [7:0] m);
		expQ.push_back({m, exp});
		host_u.xfer(1'b1, idx, 8'h00, q);
	endtask : chk

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		host_u.xfer(1'b0, idx, d, q);
	endtask : wr

	task automatic unlock(input logic [7:0] page);
		wr(`IDX_PAGE, page);
		wr(`IDX_CTRL, `CODE_KEY1);
		wr(`IDX_CTRL, `CODE_KEY2);
	endtask : unlock

	task automatic doReset();
		rst_n <= 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
	endtask : doReset

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(13392));
		doReset();
		chk(`IDX_PAGE, `PAGE_RESET, 8'hFF);
		wr(`IDX_CTRL, `CODE_PROT_SEL);
		chk(`IDX_CTRL, 8'h04, 8'h04);
		chk(`IDX_PAGE, `SECTOR_LOCK_RESET, 8'hFF);
		wr(`IDX_PAGE, 8'h80);
		wr(`IDX_PAGE, 8'h00);
		// Low byte lane disabled: the write must be ignored
		host_u.byteenable <= 4'hE;
		wr(`IDX_PAGE, 8'h01);
		host_u.byteenable <= 4'hF;
		chk(`IDX_PAGE, 8'h80, 8'hFF);
		wr(`IDX_CTRL, `CODE_RESET);
		chk(`IDX_CTRL, 8'h00, 8'h04);
		chk(`IDX_PAGE, 8'h00, 8'hFF);
		$display("lock register test done");
		// Page 28 sits in locked sector 7
		unlock(8'h1C);
		wr(`IDX_CTRL, `CODE_PAGE_ERASE);
		chk(`IDX_CTRL, 8'h0A, 8'h0B);
		wr(`IDX_CTRL, `CODE_RESET);
		chk(`IDX_CTRL, 8'h00, 8'h0F);
		$display("protected erase test done");
		unlock(8'h01);
		wr(`IDX_CTRL, `CODE_PAGE_ERASE);
		cmp({7'h00, cpuStall}, 8'h01, 8'h01);
		chk(`IDX_CTRL, 8'h01, 8'h01);
		host_u.waitIdle();
		chk(`IDX_CTRL, 8'h00, 8'h03);
		cmp({7'h00, cpuStall}, 8'h00, 8'h01);
		for (int i = 0; i < 3; i++)
		begin
			ofs = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom_range(1, 510));
			wr(`IDX_OFS_LO, ofs[7:0]);
			wr(`IDX_OFS_HI, {7'h00, ofs[8]});
			chk(`IDX_DATA, `ERASED_BYTE, 8'hFF);
		end
		$display("page erase test done");
		d1 = 8'($urandom());
		d2 = 8'($urandom());
		unlock(8'h01);
		wr(`IDX_DATA, d1);
		host_u.waitIdle();
		chk(`IDX_CTRL, 8'h02, 8'h03);
		chk(`IDX_DATA, d1, 8'hFF);
		// Second and last program of this byte before an erase
		wr(`IDX_DATA, d2);
		host_u.waitIdle();
		chk(`IDX_DATA, d1 & d2, 8'hFF);
		wr(`IDX_CTRL, 8'h11);
		chk(`IDX_CTRL, 8'h00, 8'h02);
		wr(`IDX_DATA, 8'h00);
		chk(`IDX_CTRL, 8'h00, 8'h01);
		chk(`IDX_DATA, d1 & d2, 8'hFF);
		wr(`IDX_CTRL, `CODE_PAGE_ERASE);
		chk(`IDX_CTRL, 8'h00, 8'h01);
		$display("program test done");
		doReset();
		chk(`IDX_PAGE, `PAGE_RESET, 8'hFF);
		wr(`IDX_CTRL, `CODE_PROT_SEL);
		chk(`IDX_PAGE, `SECTOR_LOCK_RESET, 8'hFF);
		wr(`IDX_CTRL, `CODE_RESET);
		unlock(8'h05);
		wr(`IDX_CTRL, `CODE_MASS_ERASE);
		chk(`IDX_CTRL, 8'h0A, 8'h0B);
		wr(`IDX_CTRL, `CODE_RESET);
		unlock(8'h05);
		host_u.setDebug(1'b1);
		wr(`IDX_CTRL, `CODE_MASS_ERASE);
		cmp({7'h00, cpuStall}, 8'h01, 8'h01);
		host_u.waitIdle();
		host_u.setDebug(1'b0);
		chk(`IDX_CTRL, 8'h00, 8'h03);
		chk(`IDX_DATA, `ERASED_BYTE, 8'hFF);
		$display("mass erase test done");
		conclude(0);
	end
endmodule : tb_top
